// ==== tb/dcrm_master_model.sv ====
// Remote bus master stand-in: sends request frames, takes reply bytes.
// The bench calls send and reads fr and rsp_q through the hierarchy.
`timescale 1ns/1ps
module dcrm_master_model (
    // Clock
    input  wire logic       sys_clk_in,
    // Request bytes
    output logic [7:0]      rx_byte_out,
    output logic            rx_valid_out,
    output logic            rx_frame_end_out,
    // Reply bytes
    input  wire logic [7:0] tx_byte_in,
    input  wire logic       tx_valid_in,
    output logic            tx_ready_out
);
    logic [7:0] fr [8];
    logic [7:0] rsp_q [$];
    initial
    begin
        rx_byte_out = 8'h5a;
        rx_valid_out = 1'b0;
        rx_frame_end_out = 1'b0;
        tx_ready_out = 1'b0;
    end
    // Slow sink: ready every other cycle
    always @(posedge sys_clk_in)
    begin
        tx_ready_out <= ~tx_ready_out;
        if (tx_valid_in && tx_ready_out)
            rsp_q.push_back(tx_byte_in);
    end
    function automatic logic [15:0] crc16(input int n);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 0; i < n; i++)
        begin
            c = c ^ {8'h00, fr[i]};
            for (int b = 0; b < 8; b++)
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        return c;
    endfunction
    task automatic send(input logic [7:0] adr, input logic [7:0] fn, input logic [15:0] ra,
                        input logic [15:0] v, input logic bad);
        logic [15:0] c;
        {fr[0], fr[1], fr[2], fr[3], fr[4], fr[5]} = {adr, fn, ra, v};
        c = crc16(6) ^ {15'h0, bad};
        {fr[7], fr[6]} = c;
        rsp_q.delete();
        for (int i = 0; i < 8; i++)
        begin
            @(posedge sys_clk_in);
            rx_byte_out <= fr[i];
            rx_valid_out <= 1'b1;
        end
        @(posedge sys_clk_in);
        rx_byte_out <= ~fr[7];
        rx_valid_out <= 1'b0;
        rx_frame_end_out <= 1'b1;
        @(posedge sys_clk_in);
        rx_frame_end_out <= 1'b0;
    endtask
endmodule

// ==== tb/tb_drive_comm_register_map.sv ====
// Bench for the drive comm register map, frames from the master model.
// Gap unit shortened to 4 cycles.
`timescale 1ns/1ps
module tb_drive_comm_register_map;
    import dcrm_pkg::*;
    logic        sys_clk_in, rst_b_in, rx_valid_in, rx_frame_end_in, tx_valid_out, tx_ready_in;
    logic        master_mode_enable_in, immediate_stop_out, fault_reset_out, nvm_store_out;
    logic        crc_error_out;
    logic [7:0]  rx_byte_in, tx_byte_out, broadcast_target_index_in;
    logic [5:0]  output_function_select_in, func_outputs_in, output_pins_out;
    logic [15:0] fault_code_in, output_freq_in, run_command_out, speed_reference_out;
    logic [15:0] torque_reference_out;
    logic [15:0] upl_o, tsl_o, mtl_o, rtl_o, psp_o, pfb_o, vfv_o, exf_o, nvd_o;
    logic [14:0] nvm_addr_out;
    logic [3:0]  pul;
    dcrm_unit_t  speed_unit_select_in;
    dcrm_src_t   broadcast_value_source_in;
    int          err_total, check_count, cyc;
    dcrm_top #(.GAP_UNIT_CYC(4)) dut (.sys_clk_in, .rst_b_in, .rx_byte_in, .rx_valid_in,
        .rx_frame_end_in, .tx_byte_out, .tx_valid_out, .tx_ready_in, .slave_addr_in(8'h01),
        .speed_unit_select_in, .master_mode_enable_in, .broadcast_target_index_in,
        .broadcast_value_source_in, .interframe_idle_time_in(16'h0001),
        .output_function_select_in, .fault_code_in, .input_status_word_in(16'h0012),
        .energy_count_in(32'h0), .output_freq_in, .func_outputs_in, .run_command_out,
        .speed_reference_out, .torque_reference_out, .upper_frequency_limit_out(upl_o),
        .torque_mode_speed_limit_out(tsl_o), .motoring_torque_limit_out(mtl_o),
        .regen_torque_limit_out(rtl_o), .pid_setpoint_out(psp_o), .pid_feedback_out(pfb_o),
        .vf_split_voltage_out(vfv_o), .external_fault_set_out(exf_o), .output_pins_out,
        .immediate_stop_out, .fault_reset_out, .nvm_store_out, .nvm_addr_out,
        .nvm_data_out(nvd_o), .crc_error_out);
    dcrm_master_model mdl (.sys_clk_in, .rx_byte_out(rx_byte_in), .rx_valid_out(rx_valid_in),
        .rx_frame_end_out(rx_frame_end_in), .tx_byte_in(tx_byte_out),
        .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready_in));
    initial
    begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Send a frame, gather event pulses for three cycles
    task automatic xfer(input logic [7:0] fn, input logic [15:0] ra, input logic [15:0] v,
                        input logic bad);
        mdl.send(8'h01, fn, ra, v, bad);
        pul = 4'h0;
        repeat (3)
        begin
            #1 pul |= {immediate_stop_out, fault_reset_out, nvm_store_out, crc_error_out};
            @(posedge sys_clk_in);
        end
    endtask
    task automatic rep(input int n);
        logic [15:0] c;
        c = mdl.crc16(n);
        {mdl.fr[n + 1], mdl.fr[n]} = c;
        for (int t = 0; t < 300 && mdl.rsp_q.size() < n + 2; t++)
            @(posedge sys_clk_in);
        for (int i = 0; i < n + 2; i++)
            chk("reply", {8'h00, mdl.fr[i]},
                i < mdl.rsp_q.size() ? {8'h00, mdl.rsp_q[i]} : 16'hffff);
    endtask
    task automatic exc(input logic [7:0] code);
        {mdl.fr[1], mdl.fr[2]} = {8'h86, code};
        rep(3);
    endtask
    task automatic t_cmd();
        for (int v = 0; v <= 9; v++)
        begin
            xfer(8'h06, 16'h7000, v[15:0], 1'b0);
            if (v == 9)
                exc(8'h04);
            else
                rep(6);
            chk("cmd", v == 9 ? 16'h0008 : v[15:0], run_command_out);
            chk("pulses", {14'h0, v == 7, v == 8}, {14'h0, pul[3:2]});
        end
    endtask
    task automatic t_limits();
        xfer(8'h06, 16'h7001, 16'hea60, 1'b0);
        rep(6);
        xfer(8'h06, 16'h7001, 16'hea61, 1'b0);
        exc(8'h04);
        chk("spd", 16'hea60, speed_reference_out);
        xfer(8'h06, 16'h7002, 16'h8ad0, 1'b0);
        rep(6);
        xfer(8'h06, 16'h7002, 16'h8acf, 1'b0);
        exc(8'h04);
        chk("trq", 16'h8ad0, torque_reference_out);
    endtask
    task automatic t_regs();
        for (int k = 3; k <= 10; k++)
        begin
            xfer(8'h06, 16'h7000 + 16'(k), 16'(k * 17), 1'b0);
            rep(6);
        end
        chk("upl", 16'h0033, upl_o);
        chk("tsl", 16'h0044, tsl_o);
        chk("mtl", 16'h0055, mtl_o);
        chk("rtl", 16'h0066, rtl_o);
        chk("psp", 16'h0077, psp_o);
        chk("pfb", 16'h0088, pfb_o);
        chk("vfv", 16'h0099, vfv_o);
        chk("exf", 16'h00aa, exf_o);
        chk("nvm data", 16'h00aa, nvd_o);
        xfer(8'h06, 16'h7005, 16'h0bb9, 1'b0);
        exc(8'h04);
        xfer(8'h06, 16'h7009, 16'h03e9, 1'b0);
        exc(8'h04);
        chk("mtl kept", 16'h0055, mtl_o);
        chk("vfv kept", 16'h0099, vfv_o);
    endtask
    task automatic t_misc();
        xfer(8'h06, 16'hf001, 16'h1234, 1'b0);
        rep(6);
        chk("nvm", {1'b1, 15'h7001}, {pul[1], nvm_addr_out});
        xfer(8'h06, 16'h7001, 16'h0001, 1'b1);
        chk("crc err", 16'h1235, {speed_reference_out[15:1], pul[0]});
        xfer(8'h06, 16'h700b, 16'h0105, 1'b0);
        rep(6);
        chk("pins", 16'h0015, {10'h0, output_pins_out});
        output_function_select_in <= 6'h00;
        fault_code_in <= 16'h0026;
        xfer(8'h03, 16'h1900, 16'h0001, 1'b0);
        chk("pins fn", 16'h002a, {10'h0, output_pins_out});
        {mdl.fr[2], mdl.fr[3], mdl.fr[4]} = 24'h020026;
        rep(5);
    endtask
    initial
    begin
        rst_b_in = 1'b0;
        master_mode_enable_in = 1'b0;
        speed_unit_select_in = DCRM_HZ;
        broadcast_value_source_in = DCRM_SRC_SPD;
        broadcast_target_index_in = 8'h00;
        output_function_select_in = 6'h3f;
        func_outputs_in = 6'h2a;
        fault_code_in = 16'h0000;
        output_freq_in = 16'h0000;
        repeat (10) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        @(posedge sys_clk_in);
        chk("reset", 16'h0000, speed_reference_out);
        t_cmd();
        t_limits();
        t_regs();
        t_misc();
        broadcast_target_index_in <= 8'h05;
        output_freq_in <= 16'h1388;
        broadcast_value_source_in <= DCRM_SRC_FRQ;
        master_mode_enable_in <= 1'b1;
        mdl.rsp_q.delete();
        {mdl.fr[0], mdl.fr[1], mdl.fr[2], mdl.fr[3], mdl.fr[4], mdl.fr[5]} = 48'h000670051388;
        rep(6);
        give_verdict();
    end
endmodule

// ==== verilog/dcrm_crc.sv ====
// Frame CRC engine, one byte per cycle.
// Init wins over feed; result is registered.
`timescale 1ns/1ps
`include "dcrm_regs.svh"
module dcrm_crc (
    // Clock and reset
    input  wire logic  sys_clk_in,
    input  wire logic  rst_b_in,
    // Byte stream
    dcrm_crc_if.calc   cif
);
    import dcrm_pkg::*;

    dcrm_crc_st_t q;
    dcrm_crc_st_t n;
    logic [15:0]  c;

    always_comb
    begin
        n = q;
        c = q.crc ^ {8'h00, cif.data};
        for (int i = 0; i < 8; i++)
        begin
            c = c[0] ? ((c >> 1) ^ `DCRM_CRC_POLY) : (c >> 1);
        end
        if (cif.init)
            n.crc = `DCRM_CRC_INIT;
        else if (cif.feed)
            n.crc = c;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            q <= '{crc: `DCRM_CRC_INIT};
        else
            q <= n;
    end

    assign cif.crc = q.crc;
endmodule

// ==== verilog/dcrm_crc_if.sv ====
// Byte-wise CRC request and result between the map and its CRC engine.
// Same clock as both ends.
`timescale 1ns/1ps
interface dcrm_crc_if;
    logic        init;
    logic        feed;
    logic [7:0]  data;
    logic [15:0] crc;
    modport calc (input init, input feed, input data, output crc);
    modport user (output init, output feed, output data, input crc);
endinterface

// ==== verilog/dcrm_pkg.sv ====
// Types of the drive comm register map.
// Constants live in dcrm_regs.svh.
package dcrm_pkg;
    typedef enum logic [1:0] {DCRM_PCT, DCRM_HZ, DCRM_RPM, DCRM_UNIT_RSV} dcrm_unit_t;
    typedef enum logic [1:0] {DCRM_SRC_SPD, DCRM_SRC_TRQ, DCRM_SRC_FRQ, DCRM_SRC_FLT} dcrm_src_t;
    typedef enum {DCRM_IDLE, DCRM_SEND, DCRM_GAP} dcrm_state_t;

    typedef struct packed {
        logic [15:0] crc;
    } dcrm_crc_st_t;

    typedef struct packed {
        dcrm_state_t      st;
        logic [7:0][7:0]  rxb;
        logic [3:0]       rxn;
        logic [15:0]      cmd, spd, trq, upl, tsl, mtl, rtl, psp, pfb, vfv, exf, doc;
        logic [5:0][7:0]  txb;
        logic [2:0]       txl;
        logic [3:0]       txi;
        logic [7:0]       txd;
        logic             txv;
        logic             exc;
        logic [5:0]       pins;
        logic             stop, frst, nvm, cerr;
        logic [14:0]      nva;
        logic [15:0]      nvd;
        logic [15:0]      ucnt, gcnt;
    } dcrm_top_st_t;
endpackage

// ==== verilog/dcrm_regs.svh ====
// Offsets, field values, ranges and timing of the drive comm register map.
// Assumes 16-bit register words and a 50 MHz system clock.
`ifndef DCRM_REGS_SVH
`define DCRM_REGS_SVH

`define DCRM_CLK_NS      20
`define DCRM_GAP_UNIT_NS 1000000

`define DCRM_A_CMD  15'h7000
`define DCRM_A_SPD  15'h7001
`define DCRM_A_TRQ  15'h7002
`define DCRM_A_UPL  15'h7003
`define DCRM_A_TSL  15'h7004
`define DCRM_A_MTL  15'h7005
`define DCRM_A_RTL  15'h7006
`define DCRM_A_PSP  15'h7007
`define DCRM_A_PFB  15'h7008
`define DCRM_A_VFV  15'h7009
`define DCRM_A_EXF  15'h700a
`define DCRM_A_DOC  15'h700b
`define DCRM_A_FLT  15'h1900
`define DCRM_A_DIN  15'h0600
`define DCRM_A_E32L 15'h1000
`define DCRM_A_E32H 15'h1001
`define DCRM_NVM_BIT 15

`define DCRM_FN_RD  8'h03
`define DCRM_FN_WR  8'h06
`define DCRM_FN_EXC 8'h80
`define DCRM_EX_FN  8'h01
`define DCRM_EX_ADR 8'h02
`define DCRM_EX_RNG 8'h04
`define DCRM_EX_RO  8'h05
`define DCRM_NO_EXC 8'h00

`define DCRM_CRC_POLY 16'ha001
`define DCRM_CRC_INIT 16'hffff

`define DCRM_CMD_STOP 16'h0007
`define DCRM_CMD_FRST 16'h0008
`define DCRM_CMD_MAX  16'h0008
`define DCRM_PCT100   16'h2710
`define DCRM_PCT300   16'h7530
`define DCRM_HZ_MAX   16'hea60
`define DCRM_LIM_MAX  16'h0bb8
`define DCRM_VF_MAX   16'h03e8
`define DCRM_REG_RST  16'h0000

`define DCRM_BC_ADDR 8'h00
`define DCRM_BC_HI   8'h70

`endif

// ==== verilog/dcrm_top.sv ====
// Drive comm register map: frame slave, special registers, broadcast master.
// Frame bytes arrive already deframed; rx_frame_end_in marks line silence.
`timescale 1ns/1ps
`include "dcrm_regs.svh"
module dcrm_top #(
    parameter int unsigned GAP_UNIT_CYC = `DCRM_GAP_UNIT_NS / `DCRM_CLK_NS
) (
    // Clock and reset
    input  wire logic                 sys_clk_in,
    input  wire logic                 rst_b_in,
    // Received frame bytes
    input  wire logic [7:0]           rx_byte_in,
    input  wire logic                 rx_valid_in,
    input  wire logic                 rx_frame_end_in,
    // Transmitted frame bytes
    output logic [7:0]                tx_byte_out,
    output logic                      tx_valid_out,
    input  wire logic                 tx_ready_in,
    // Settings
    input  wire logic [7:0]           slave_addr_in,
    input  wire dcrm_pkg::dcrm_unit_t speed_unit_select_in,
    input  wire logic                 master_mode_enable_in,
    input  wire logic [7:0]           broadcast_target_index_in,
    input  wire dcrm_pkg::dcrm_src_t  broadcast_value_source_in,
    input  wire logic [15:0]          interframe_idle_time_in,
    input  wire logic [5:0]           output_function_select_in,
    // Drive state
    input  wire logic [15:0]          fault_code_in,
    input  wire logic [15:0]          input_status_word_in,
    input  wire logic [31:0]          energy_count_in,
    input  wire logic [15:0]          output_freq_in,
    input  wire logic [5:0]           func_outputs_in,
    // Register values
    output logic [15:0]               run_command_out,
    output logic [15:0]               speed_reference_out,
    output logic [15:0]               torque_reference_out,
    output logic [15:0]               upper_frequency_limit_out,
    output logic [15:0]               torque_mode_speed_limit_out,
    output logic [15:0]               motoring_torque_limit_out,
    output logic [15:0]               regen_torque_limit_out,
    output logic [15:0]               pid_setpoint_out,
    output logic [15:0]               pid_feedback_out,
    output logic [15:0]               vf_split_voltage_out,
    output logic [15:0]               external_fault_set_out,
    output logic [5:0]                output_pins_out,
    // Events
    output logic                      immediate_stop_out,
    output logic                      fault_reset_out,
    output logic                      nvm_store_out,
    output logic [14:0]               nvm_addr_out,
    output logic [15:0]               nvm_data_out,
    output logic                      crc_error_out
);
    import dcrm_pkg::*;

    dcrm_top_st_t q;
    dcrm_top_st_t n;
    dcrm_crc_if   rcif ();
    dcrm_crc_if   tcif ();

    logic [7:0]  fn;
    logic [15:0] ra;
    logic [15:0] rd;
    logic        frm_ok;
    logic        adr_me;
    logic        go;
    logic        wr_try;
    logic        wr_go;
    logic        bc_load;
    logic [7:0]  exc_c;
    logic [16:0] rdv;
    logic [15:0] bcv;
    logic [3:0]  last_i;
    logic [5:0]  doc_sel;

    assign fn     = q.rxb[1];
    assign ra     = {q.rxb[2], q.rxb[3]};
    assign rd     = {q.rxb[4], q.rxb[5]};
    assign last_i = {1'b0, q.txl} + 4'd1;
    assign doc_sel = {q.doc[9:8], q.doc[3:0]};
    // Whole frame incl. CRC leaves a zero residue
    assign frm_ok = rx_frame_end_in && q.rxn == 4'd8 && rcif.crc == 16'h0000;
    assign adr_me = q.rxb[0] == slave_addr_in || q.rxb[0] == `DCRM_BC_ADDR;
    assign go     = frm_ok && adr_me && q.st == DCRM_IDLE;

    // Value check of a special register write
    function automatic logic rng_ok(input logic [14:0] a, input logic [15:0] d,
                                    input dcrm_unit_t u);
        logic pct;
        pct = $signed(d) <= $signed(`DCRM_PCT100) && $signed(d) >= -$signed(`DCRM_PCT100);
        case (a)
            `DCRM_A_CMD: rng_ok = d <= `DCRM_CMD_MAX;
            `DCRM_A_SPD, `DCRM_A_UPL, `DCRM_A_TSL:
                case (u)
                    DCRM_PCT: rng_ok = pct;
                    DCRM_HZ:  rng_ok = d <= `DCRM_HZ_MAX;
                    DCRM_RPM: rng_ok = 1'b1;
                    default:  rng_ok = 1'b0;
                endcase
            `DCRM_A_TRQ: rng_ok = $signed(d) <= $signed(`DCRM_PCT300) &&
                                  $signed(d) >= -$signed(`DCRM_PCT300);
            `DCRM_A_MTL, `DCRM_A_RTL: rng_ok = d <= `DCRM_LIM_MAX;
            `DCRM_A_PSP, `DCRM_A_PFB: rng_ok = pct;
            `DCRM_A_VFV: rng_ok = d <= `DCRM_VF_MAX;
            `DCRM_A_EXF, `DCRM_A_DOC: rng_ok = 1'b1;
            default: rng_ok = 1'b0;
        endcase
    endfunction

    // Read mux: hit flag on top
    always_comb
    begin
        case (ra[14:0])
            `DCRM_A_CMD:  rdv = {1'b1, q.cmd};
            `DCRM_A_SPD:  rdv = {1'b1, q.spd};
            `DCRM_A_TRQ:  rdv = {1'b1, q.trq};
            `DCRM_A_UPL:  rdv = {1'b1, q.upl};
            `DCRM_A_TSL:  rdv = {1'b1, q.tsl};
            `DCRM_A_MTL:  rdv = {1'b1, q.mtl};
            `DCRM_A_RTL:  rdv = {1'b1, q.rtl};
            `DCRM_A_PSP:  rdv = {1'b1, q.psp};
            `DCRM_A_PFB:  rdv = {1'b1, q.pfb};
            `DCRM_A_VFV:  rdv = {1'b1, q.vfv};
            `DCRM_A_EXF:  rdv = {1'b1, q.exf};
            `DCRM_A_DOC:  rdv = {1'b1, q.doc};
            `DCRM_A_FLT:  rdv = {1'b1, fault_code_in};
            `DCRM_A_DIN:  rdv = {1'b1, input_status_word_in};
            `DCRM_A_E32L: rdv = {1'b1, energy_count_in[15:0]};
            `DCRM_A_E32H: rdv = {1'b1, energy_count_in[31:16]};
            default:      rdv = 17'h00000;
        endcase
    end

    always_comb
    begin
        case (broadcast_value_source_in)
            DCRM_SRC_SPD: bcv = q.spd;
            DCRM_SRC_TRQ: bcv = q.trq;
            DCRM_SRC_FRQ: bcv = output_freq_in;
            default:      bcv = fault_code_in;
        endcase
    end

    always_comb
    begin
        n = q;
        n.stop = 1'b0;
        n.frst = 1'b0;
        n.nvm = 1'b0;
        n.cerr = 1'b0;
        exc_c = `DCRM_NO_EXC;
        wr_try = 1'b0;
        wr_go = 1'b0;
        bc_load = 1'b0;
        // Collect bytes; count saturates at 9 for overlong frames
        if (rx_valid_in)
        begin
            if (q.rxn < 4'd8)
                n.rxb[q.rxn[2:0]] = rx_byte_in;
            if (q.rxn != 4'd9)
                n.rxn = q.rxn + 4'd1;
        end
        if (rx_frame_end_in)
        begin
            n.rxn = 4'h0;
            n.cerr = q.rxn != 4'h0 && !frm_ok;
        end
        if (go)
        begin
            case (fn)
                `DCRM_FN_WR:
                begin
                    wr_try = ra[14:0] >= `DCRM_A_CMD && ra[14:0] <= `DCRM_A_DOC;
                    if (wr_try && rng_ok(ra[14:0], rd, speed_unit_select_in))
                        wr_go = 1'b1;
                    else if (wr_try)
                        exc_c = `DCRM_EX_RNG;
                    else if (rdv[16])
                        exc_c = `DCRM_EX_RO;
                    else
                        exc_c = `DCRM_EX_ADR;
                end
                `DCRM_FN_RD:
                    if (rd != 16'h0001 || !rdv[16])
                        exc_c = `DCRM_EX_ADR;
                default: exc_c = `DCRM_EX_FN;
            endcase
            if (wr_go)
            begin
                case (ra[14:0])
                    `DCRM_A_CMD: n.cmd = rd;
                    `DCRM_A_SPD: n.spd = rd;
                    `DCRM_A_TRQ: n.trq = rd;
                    `DCRM_A_UPL: n.upl = rd;
                    `DCRM_A_TSL: n.tsl = rd;
                    `DCRM_A_MTL: n.mtl = rd;
                    `DCRM_A_RTL: n.rtl = rd;
                    `DCRM_A_PSP: n.psp = rd;
                    `DCRM_A_PFB: n.pfb = rd;
                    `DCRM_A_VFV: n.vfv = rd;
                    `DCRM_A_EXF: n.exf = rd;
                    default:     n.doc = rd;
                endcase
                n.stop = ra[14:0] == `DCRM_A_CMD && rd == `DCRM_CMD_STOP;
                n.frst = ra[14:0] == `DCRM_A_CMD && rd == `DCRM_CMD_FRST;
                n.nvm = ra[`DCRM_NVM_BIT];
                n.nva = ra[14:0];
                n.nvd = rd;
            end
            // Broadcasts and master mode get no reply
            if (q.rxb[0] != `DCRM_BC_ADDR && !master_mode_enable_in)
            begin
                n.st = DCRM_SEND;
                n.txi = 4'h0;
                n.txv = 1'b0;
                n.exc = exc_c != `DCRM_NO_EXC;
                n.txb[0] = q.rxb[0];
                if (exc_c != `DCRM_NO_EXC)
                begin
                    n.txb[1] = fn | `DCRM_FN_EXC;
                    n.txb[2] = exc_c;
                    n.txl = 3'd3;
                end
                else if (fn == `DCRM_FN_RD)
                begin
                    n.txb[1] = fn;
                    n.txb[2] = 8'h02;
                    n.txb[3] = rdv[15:8];
                    n.txb[4] = rdv[7:0];
                    n.txl = 3'd5;
                end
                else
                begin
                    n.txb = q.rxb[5:0];
                    n.txl = 3'd6;
                end
            end
        end
        else if (q.st == DCRM_IDLE && master_mode_enable_in)
        begin
            bc_load = 1'b1;
            n.st = DCRM_SEND;
            n.txi = 4'h0;
            n.txv = 1'b0;
            n.exc = 1'b0;
            n.txb = {bcv[7:0], bcv[15:8], broadcast_target_index_in,
                     `DCRM_BC_HI, `DCRM_FN_WR, `DCRM_BC_ADDR};
            n.txl = 3'd6;
        end
        case (q.st)
            DCRM_IDLE: ;
            DCRM_SEND:
                if (!q.txv)
                begin
                    n.txv = 1'b1;
                    if (q.txi < {1'b0, q.txl})
                        n.txd = q.txb[q.txi[2:0]];
                    else if (q.txi == {1'b0, q.txl})
                        n.txd = tcif.crc[7:0];
                    else
                        n.txd = tcif.crc[15:8];
                end
                else if (tx_ready_in)
                begin
                    n.txv = 1'b0;
                    n.txi = q.txi + 4'd1;
                    if (q.txi == last_i)
                    begin
                        n.st = master_mode_enable_in ? DCRM_GAP : DCRM_IDLE;
                        n.ucnt = 16'h0000;
                        n.gcnt = 16'h0000;
                    end
                end
            DCRM_GAP:
                if (q.gcnt >= interframe_idle_time_in)
                    n.st = DCRM_IDLE;
                else if (q.ucnt == 16'(GAP_UNIT_CYC - 1))
                begin
                    n.ucnt = 16'h0000;
                    n.gcnt = q.gcnt + 16'h0001;
                end
                else
                    n.ucnt = q.ucnt + 16'h0001;
            default: n.st = DCRM_IDLE;
        endcase
        n.pins = (output_function_select_in & doc_sel) |
                 (~output_function_select_in & func_outputs_in);
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            q <= '0;
            q.st <= DCRM_IDLE;
        end
        else
            q <= n;
    end

    assign rcif.init = rx_frame_end_in;
    assign rcif.feed = rx_valid_in && q.rxn < 4'd8;
    assign rcif.data = rx_byte_in;
    assign tcif.init = q.st != DCRM_SEND;
    assign tcif.feed = q.st == DCRM_SEND && q.txv && tx_ready_in && q.txi < {1'b0, q.txl};
    assign tcif.data = q.txd;

    dcrm_crc u_rx_crc (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .cif        (rcif.calc)
    );

    dcrm_crc u_tx_crc (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .cif        (tcif.calc)
    );

    assign tx_byte_out = q.txd;
    assign tx_valid_out = q.txv;
    assign run_command_out = q.cmd;
    assign speed_reference_out = q.spd;
    assign torque_reference_out = q.trq;
    assign upper_frequency_limit_out = q.upl;
    assign torque_mode_speed_limit_out = q.tsl;
    assign motoring_torque_limit_out = q.mtl;
    assign regen_torque_limit_out = q.rtl;
    assign pid_setpoint_out = q.psp;
    assign pid_feedback_out = q.pfb;
    assign vf_split_voltage_out = q.vfv;
    assign external_fault_set_out = q.exf;
    assign output_pins_out = q.pins;
    assign immediate_stop_out = q.stop;
    assign fault_reset_out = q.frst;
    assign nvm_store_out = q.nvm;
    assign nvm_addr_out = q.nva;
    assign nvm_data_out = q.nvd;
    assign crc_error_out = q.cerr;

    stop_cmd_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        wr_go && ra[14:0] == `DCRM_A_CMD && rd == `DCRM_CMD_STOP
        |=> immediate_stop_out && run_command_out == `DCRM_CMD_STOP ##1 !immediate_stop_out)
        else $error("immediate stop not pulsed");
    fault_reset_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        wr_go && ra[14:0] == `DCRM_A_CMD && rd == `DCRM_CMD_FRST |=> fault_reset_out)
        else $error("fault reset not pulsed");
    speed_reject_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        wr_try && !wr_go && ra[14:0] == `DCRM_A_SPD && q.rxb[0] != `DCRM_BC_ADDR
        |=> $stable(speed_reference_out) && (master_mode_enable_in || q.exc))
        else $error("out of range speed write accepted");
    torque_span_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        $signed(torque_reference_out) <= $signed(`DCRM_PCT300) &&
        $signed(torque_reference_out) >= -$signed(`DCRM_PCT300))
        else $error("torque reference out of range");
    limit_span_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        motoring_torque_limit_out <= `DCRM_LIM_MAX && regen_torque_limit_out <= `DCRM_LIM_MAX
        && vf_split_voltage_out <= `DCRM_VF_MAX)
        else $error("limit register out of range");
    out_follow_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        output_function_select_in[2] |=> output_pins_out[2] == $past(q.doc[2]))
        else $error("relay one not following control bit");
    exc_func_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        tx_valid_out && q.txi == 4'd1 && q.exc |-> tx_byte_out[7])
        else $error("exception reply without 0x80 flag");
    bc_head_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        bc_load |=> ##1 tx_valid_out && tx_byte_out == `DCRM_BC_ADDR)
        else $error("broadcast frame does not start with 00");
    gap_quiet_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        q.st == DCRM_GAP |-> !tx_valid_out)
        else $error("byte sent during idle gap");
    nvm_save_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        wr_go && ra[15] |=> nvm_store_out && nvm_addr_out == $past(ra[14:0]))
        else $error("nonvolatile save not requested");
endmodule
